// ### inc/lp_osc_pkg.sv
// Constants and types shared by the low-frequency oscillator control block
package lp_osc_pkg;

	// ========================================
	// Timing
	localparam int CLK_FREQ_HZ = 25_000_000;
	localparam int CLK_PER_US = CLK_FREQ_HZ / 1_000_000;
	// Detection window, typical and maximum
	localparam int FAIL_WINDOW_TYP_US = 2000;
	localparam int FAIL_WINDOW_MAX_US = 4000;
	// Window uses the typical time, not the longest allowed
	localparam int FAIL_WINDOW_CYCLES = FAIL_WINDOW_TYP_US * CLK_PER_US;
	// Arming delay; no figure given, plain default
	localparam int ARM_DELAY_US = 500;
	localparam int ARM_DELAY_CYCLES = ARM_DELAY_US * CLK_PER_US;

	// ========================================
	// Register bus
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam logic [ADDR_W-1:0] REG_OSC_CONTROL = 4'h0;
	localparam logic [ADDR_W-1:0] REG_OSC_STATUS = 4'h1;

	// osc_control_register fields
	localparam int BIT_SWITCH_REQ = 0;
	localparam int BIT_KEEP_ON = 1;
	localparam int BIT_CLOCK_FAIL = 3;
	localparam int NEXT_SRC_LSB = 8;
	localparam int CUR_SRC_LSB = 12;
	localparam int SRC_W = 3;

	// Clock source codes
	localparam logic [SRC_W-1:0] SRC_FAST_RC = 3'h0;
	localparam logic [SRC_W-1:0] SRC_FAST_RC_PLL = 3'h1;
	localparam logic [SRC_W-1:0] SRC_PRIMARY = 3'h2;
	localparam logic [SRC_W-1:0] SRC_PRIMARY_PLL = 3'h3;
	localparam logic [SRC_W-1:0] SRC_SECONDARY = 3'h4;
	localparam logic [SRC_W-1:0] SRC_LOW_POWER_RC = 3'h5;

	// switch_monitor_mode and powerup_timer_select encodings
	localparam logic [1:0] MODE_SWITCH_AND_MONITOR = 2'h0;
	localparam int MODE_BIT_SWITCH_OFF = 1;
	localparam logic [2:0] POWERUP_TIMER_SEL_OFF = 3'h0;

	// ========================================
	// Types
	typedef struct packed {
		logic primary;
		logic fast_rc;
		logic secondary;
		logic low_power_rc;
	} osc_enables_t;

	typedef struct packed {
		logic [SRC_W-1:0] initial_source_select;
		logic [2:0] powerup_timer_select;
		logic [1:0] switch_monitor_mode;
	} config_bits_t;

	typedef enum logic [1:0] {
		MON_IDLE,
		MON_ARMING,
		MON_WATCH,
		MON_FAILED
	} monitor_state_t;

endpackage : lp_osc_pkg

// ### hw/sync_2ff.sv
// Two-stage synchroniser for signals entering the core clock domain
module sync_2ff #(
	parameter int WIDTH = 1
) (
	input wire logic core_clk_in, // Core clock
	input wire logic reset_n_in, // Async reset, active low
	input wire logic [WIDTH-1:0] async_in, // Signals from another domain
	output logic [WIDTH-1:0] sync_out // Synchronised signals
);

	logic [WIDTH-1:0] stage_one;

	// First stage feeds the second only
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			stage_one <= '0;
			sync_out <= '0;
		end else begin
			stage_one <= async_in;
			sync_out <= stage_one;
		end
	end

endmodule : sync_2ff

// ### hw/lp_osc_ctrl.sv
// Low-frequency oscillator enables and fail-safe clock monitor
// Function
// [RULE_01] Secondary crystal is system clock by initial select or completed switch.
// [RULE_02] Secondary crystal off when not system clock or in Sleep, unless kept on.
// [RULE_03] Keep-on bit holds secondary crystal enabled whatever source is selected.
// [RULE_04] Sleep stops primary, fast RC and low-power RC; secondary only if kept on. Here low-power RC stays on in Sleep with watchdog enabled.
// [RULE_05] Low-power RC is system clock by initial select or completed switch.
// [RULE_06] Low-power RC enabled at power-on when power-up timer select is set.
// [RULE_07] After power-up timer, low-power RC stays on for monitor, watchdog or system clock.
// [RULE_08] In Sleep low-power RC runs only with watchdog enabled.
// [RULE_09] Low-power RC counts as ready at once, no start-up delay.
// [RULE_10] Mode 00 enables monitor and keeps low-power RC on except in Sleep.
// [RULE_11] No clock activity within window raises trap and switches to fast RC.
// [RULE_12] A clock failure during Sleep produces no trap or wake event.
// [RULE_13] Fail-safe switch loads current source field with the fast RC code.
// [RULE_14] Fail-safe switch sets the clock-fail flag.
// [RULE_15] Fail-safe switch clears the switch request bit.
// [RULE_16] Monitor checks only after clock ready and arming delay elapsed.
// [RULE_17] Arming delay applies only with monitor on and a crystal source selected.
// [RULE_18] Watchdog keeps its low-power RC clock through a clock failure.
// [RULE_19] Monitor enabled only when switching is enabled; first mode bit disables both.
// [RULE_20] Window counter restarted by synchronised activity, trap a single pulse.
// [RULE_21] Clock-fail flag holds until a valid switch or a reset.
module lp_osc_ctrl
	import lp_osc_pkg::*;
#(
	parameter int WINDOW_CYCLES = FAIL_WINDOW_CYCLES,
	parameter int ARM_CYCLES = ARM_DELAY_CYCLES
) (
	input wire logic core_clk_in, // Core clock, 25 MHz
	input wire logic reset_n_in, // Power-on reset, async, active low
	input wire config_bits_t config_in, // Configuration word, static
	input wire logic watchdog_enable_in, // Watchdog enabled
	input wire logic sleep_in, // Device in Sleep
	input wire logic powerup_timer_done_in, // Power-up timer expired
	input wire logic sys_clk_ready_in, // System clock ready, async
	input wire logic sys_clk_toggle_in, // Toggles on system clock activity, async
	input wire logic switch_done_in, // Sequencer finished a switch, pulse
	input wire logic [ADDR_W-1:0] addr_in, // Register address
	input wire logic [DATA_W-1:0] wdata_in, // Write data
	input wire logic wr_in, // Write strobe
	input wire logic rd_in, // Read strobe
	output logic [DATA_W-1:0] rdata_out, // Read data, cycle after strobe
	output osc_enables_t osc_enable_out, // Oscillator enables
	output logic [SRC_W-1:0] current_source_out, // Current system clock source
	output logic switch_request_out, // Switch pending for sequencer
	output logic [SRC_W-1:0] next_source_out, // Requested source
	output logic clock_fail_trap_out // Clock-failure trap, one pulse
);

	// ========================================
	// Helpers
	function automatic logic is_crystal(input logic [SRC_W-1:0] src);
		return (src == SRC_PRIMARY) || (src == SRC_PRIMARY_PLL) || (src == SRC_SECONDARY);
	endfunction : is_crystal

	function automatic logic is_primary(input logic [SRC_W-1:0] src);
		return (src == SRC_PRIMARY) || (src == SRC_PRIMARY_PLL);
	endfunction : is_primary

	function automatic logic is_fast_rc(input logic [SRC_W-1:0] src);
		return (src == SRC_FAST_RC) || (src == SRC_FAST_RC_PLL);
	endfunction : is_fast_rc

	localparam int WIN_W = $clog2(WINDOW_CYCLES + 1);
	localparam int ARM_W = $clog2(ARM_CYCLES + 1);
	localparam logic [WIN_W-1:0] WIN_LAST = WIN_W'(WINDOW_CYCLES - 1);
	localparam logic [ARM_W-1:0] ARM_LAST = ARM_W'(ARM_CYCLES - 1);

	// ========================================
	// Synchronisers and configuration
	logic [1:0] synced;
	logic activity_prev;
	logic activity;
	logic clk_ready;
	logic strap_taken;
	logic switching_enabled;
	logic monitor_enabled;

	sync_2ff #(
		.WIDTH(2)
	) u_sync (
		.core_clk_in(core_clk_in),
		.reset_n_in(reset_n_in),
		.async_in({sys_clk_ready_in, sys_clk_toggle_in}),
		.sync_out(synced)
	);

	assign clk_ready = synced[1];
	assign activity = synced[0] ^ activity_prev; // [RULE_20]
	assign switching_enabled = !config_in.switch_monitor_mode[MODE_BIT_SWITCH_OFF]; // [RULE_19]
	assign monitor_enabled = (config_in.switch_monitor_mode == MODE_SWITCH_AND_MONITOR); // [RULE_10]

	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			activity_prev <= 1'b0;
		end else begin
			activity_prev <= synced[0];
		end
	end

	// ========================================
	// Control register
	logic keep_on;
	logic clock_fail;
	logic fail_event;
	logic valid_switch;
	logic ctrl_write;

	assign ctrl_write = wr_in && (addr_in == REG_OSC_CONTROL);
	// A request, with switching enabled and none pending, that differs from the current source clears the fail flag
	assign valid_switch = ctrl_write && wdata_in[BIT_SWITCH_REQ] && switching_enabled
		&& !switch_request_out
		&& (wdata_in[NEXT_SRC_LSB +: SRC_W] != current_source_out);

	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			keep_on <= 1'b0;
			next_source_out <= SRC_FAST_RC;
		end else if (ctrl_write) begin
			keep_on <= wdata_in[BIT_KEEP_ON]; // [RULE_03]
			if (!switch_request_out) begin
				next_source_out <= wdata_in[NEXT_SRC_LSB +: SRC_W];
			end
		end
	end

	// Straps are caught after release, never under the async reset
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			strap_taken <= 1'b0;
			current_source_out <= SRC_FAST_RC;
		end else if (!strap_taken) begin
			strap_taken <= 1'b1;
			current_source_out <= config_in.initial_source_select; // [RULE_01] [RULE_05]
		end else if (fail_event) begin
			current_source_out <= SRC_FAST_RC; // [RULE_13]
		end else if (switch_done_in && switch_request_out) begin
			current_source_out <= next_source_out; // [RULE_01] [RULE_05]
		end
	end

	// Fail cancel beats a software set in the same cycle
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			switch_request_out <= 1'b0;
		end else if (fail_event) begin
			switch_request_out <= 1'b0; // [RULE_15]
		end else if (switch_done_in && switch_request_out) begin
			switch_request_out <= 1'b0;
		end else if (valid_switch) begin
			switch_request_out <= 1'b1; // [RULE_19]
		end
	end

	// Failure set wins over clear by a new switch
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			clock_fail <= 1'b0;
		end else if (fail_event) begin
			clock_fail <= 1'b1; // [RULE_14]
		end else if (valid_switch) begin
			clock_fail <= 1'b0; // [RULE_21]
		end
	end

	// ========================================
	// Fail-safe monitor
	monitor_state_t mon_state;
	logic [WIN_W-1:0] win_cnt;
	logic [ARM_W-1:0] arm_cnt;
	logic mon_run;
	logic expired;

	// Sleep returns the monitor to idle so a dead clock raises nothing
	assign mon_run = monitor_enabled && !sleep_in; // [RULE_12] [RULE_19]
	assign expired = mon_run && (mon_state == MON_WATCH) && !activity && (win_cnt == WIN_LAST);
	assign fail_event = expired; // [RULE_11]

	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			mon_state <= MON_IDLE;
			arm_cnt <= '0;
		end else if (!mon_run) begin
			mon_state <= MON_IDLE;
			arm_cnt <= '0;
		end else begin
			case (mon_state)
				MON_IDLE: begin
					arm_cnt <= '0;
					if (clk_ready && strap_taken) begin // [RULE_16]
						if (is_crystal(current_source_out)) begin
							mon_state <= MON_ARMING; // [RULE_17]
						end else begin
							mon_state <= MON_WATCH;
						end
					end
				end
				MON_ARMING: begin
					arm_cnt <= arm_cnt + 1'b1;
					if (arm_cnt == ARM_LAST) begin
						mon_state <= MON_WATCH; // [RULE_16]
					end
				end
				MON_WATCH: begin
					if (expired) begin
						mon_state <= MON_FAILED;
					end
				end
				MON_FAILED: begin
					if (switch_done_in && switch_request_out) begin
						mon_state <= MON_IDLE;
					end
				end
				default: begin
					mon_state <= MON_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			win_cnt <= '0;
		end else if (!mon_run || mon_state != MON_WATCH || activity) begin
			win_cnt <= '0; // [RULE_20]
		end else if (win_cnt != WIN_LAST) begin
			win_cnt <= win_cnt + 1'b1;
		end
	end

	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			clock_fail_trap_out <= 1'b0;
		end else begin
			clock_fail_trap_out <= fail_event; // [RULE_20]
		end
	end

	// ========================================
	// Oscillator enables
	osc_enables_t next_enables;
	logic powerup_timer_base;

	assign powerup_timer_base = (config_in.powerup_timer_select != POWERUP_TIMER_SEL_OFF) && !powerup_timer_done_in;

	always_comb begin
		next_enables = '0;
		next_enables.secondary = keep_on // [RULE_03]
			|| (!sleep_in && (current_source_out == SRC_SECONDARY
			|| (switch_request_out && next_source_out == SRC_SECONDARY))); // [RULE_02]
		if (!sleep_in) begin
			next_enables.primary = is_primary(current_source_out)
				|| (switch_request_out && is_primary(next_source_out));
			next_enables.fast_rc = is_fast_rc(current_source_out)
				|| (switch_request_out && is_fast_rc(next_source_out));
			// Failure leaves this term alone so the watchdog keeps ticking
			next_enables.low_power_rc = powerup_timer_base || monitor_enabled || watchdog_enable_in
				|| current_source_out == SRC_LOW_POWER_RC
				|| (switch_request_out && next_source_out == SRC_LOW_POWER_RC); // [RULE_06] [RULE_07] [RULE_10] [RULE_18]
		end else begin
			next_enables.low_power_rc = watchdog_enable_in; // [RULE_04] [RULE_08]
		end
	end

	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			osc_enable_out <= '0;
		end else begin
			osc_enable_out <= next_enables; // [RULE_09]
		end
	end

	// ========================================
	// Read port
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rdata_out <= '0;
		end else if (rd_in && addr_in == REG_OSC_CONTROL) begin
			rdata_out <= '0;
			rdata_out[CUR_SRC_LSB +: SRC_W] <= current_source_out;
			rdata_out[NEXT_SRC_LSB +: SRC_W] <= next_source_out;
			rdata_out[BIT_CLOCK_FAIL] <= clock_fail;
			rdata_out[BIT_KEEP_ON] <= keep_on;
			rdata_out[BIT_SWITCH_REQ] <= switch_request_out;
		end else if (rd_in && addr_in == REG_OSC_STATUS) begin
			rdata_out <= {{(DATA_W - 6){1'b0}}, mon_state, osc_enable_out};
		end else begin
			rdata_out <= '0;
		end
	end

	// ========================================
	// Checks
	sequence s_trap_pulse;
		clock_fail_trap_out ##1 !clock_fail_trap_out;
	endsequence

	sequence s_fail_state;
		current_source_out == SRC_FAST_RC && clock_fail && !switch_request_out;
	endsequence

	property p_window_trap;
		@(posedge core_clk_in) disable iff (!reset_n_in)
		expired |=> s_trap_pulse;
	endproperty
	a_window_trap: assert property (p_window_trap) else $error("trap missing after window"); // [RULE_11]

	property p_fail_effects;
		@(posedge core_clk_in) disable iff (!reset_n_in)
		clock_fail_trap_out |-> s_fail_state;
	endproperty
	a_fail_effects: assert property (p_fail_effects) else $error("fail switch effects wrong"); // [RULE_13]

	property p_no_trap_sleep;
		@(posedge core_clk_in) disable iff (!reset_n_in)
		sleep_in |=> !clock_fail_trap_out;
	endproperty
	a_no_trap_sleep: assert property (p_no_trap_sleep) else $error("trap during sleep"); // [RULE_12]

	property p_keep_on;
		@(posedge core_clk_in) disable iff (!reset_n_in)
		keep_on |=> osc_enable_out.secondary;
	endproperty
	a_keep_on: assert property (p_keep_on) else $error("secondary off with keep-on"); // [RULE_03]

	property p_sleep_stops;
		@(posedge core_clk_in) disable iff (!reset_n_in)
		sleep_in && !keep_on && !watchdog_enable_in |=> osc_enable_out == '0;
	endproperty
	a_sleep_stops: assert property (p_sleep_stops) else $error("oscillator on in sleep"); // [RULE_04]

	property p_monitor_low_power_rc_osc;
		@(posedge core_clk_in) disable iff (!reset_n_in)
		monitor_enabled && !sleep_in |=> osc_enable_out.low_power_rc;
	endproperty
	a_monitor_low_power_rc_osc: assert property (p_monitor_low_power_rc_osc) else $error("low-power RC off with monitor"); // [RULE_10]

	property p_no_monitor;
		@(posedge core_clk_in) disable iff (!reset_n_in)
		!monitor_enabled |-> mon_state == MON_IDLE ##1 !clock_fail_trap_out;
	endproperty
	a_no_monitor: assert property (p_no_monitor) else $error("monitor active while disabled"); // [RULE_19]

	property p_cf_hold;
		@(posedge core_clk_in) disable iff (!reset_n_in)
		clock_fail && !valid_switch |=> clock_fail;
	endproperty
	a_cf_hold: assert property (p_cf_hold) else $error("clock-fail flag dropped"); // [RULE_21]

	property p_arming;
		@(posedge core_clk_in) disable iff (!reset_n_in)
		mon_state == MON_IDLE && mon_run && clk_ready && strap_taken
			&& !is_crystal(current_source_out) |=> mon_state == MON_WATCH;
	endproperty
	a_arming: assert property (p_arming) else $error("arming delay on non-crystal"); // [RULE_17]

endmodule : lp_osc_ctrl

// ### bench/sys_clk_model.sv
// Model of the system clock multiplexer and oscillators beyond the block
module sys_clk_model (
	input wire logic core_clk_in, // Core clock
	input wire logic reset_n_in, // Async reset, active low
	input wire logic switch_request_in, // Pending switch from the block
	input wire logic stop_in, // Bench command: system clock dead
	input wire logic [7:0] delay_in, // Cycles until a switch completes
	output logic ready_out, // System clock ready
	output logic toggle_out, // Activity toggle
	output logic switch_done_out // Switch finished, one pulse
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] count;

	// ========================================
	// Clock activity
	// A dead clock stands still, so no stale toggle passes for activity
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ready_out <= 1'b0;
			toggle_out <= 1'b0;
		end else begin
			ready_out <= 1'b1;
			toggle_out <= stop_in ? toggle_out : ~toggle_out;
		end
	end

	// ========================================
	// Switch completion, prompt or slow
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			count <= 8'h00;
			switch_done_out <= 1'b0;
		end else begin
			switch_done_out <= 1'b0;
			if (!switch_request_in || switch_done_out) begin
				count <= 8'h00;
			end else if (count == delay_in) begin
				switch_done_out <= 1'b1;
				count <= 8'h00;
			end else begin
				count <= count + 8'h01;
			end
		end
	end
endmodule : sys_clk_model

// ### bench/testbench.sv
// Self-checking bench for the low-frequency oscillator control block
module testbench
	import lp_osc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, reset_n, wdt, sleep, pdone, wr, rd, trap, req, ready, toggle, done, stop;
	config_bits_t cfg;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata, rdata, rv;
	logic [SRC_W-1:0] cur, nxt;
	osc_enables_t en;
	logic [7:0] delay;
	int num_errors, tests_run, traps, cycles, i;
	// Flags: watchdog, sleep, timer done, expected secondary, expected low-power rc
	typedef struct packed {
		config_bits_t c;
		logic [4:0] f;
	} row_t;
	row_t rows [10] = '{'{8'h83, 5'b00110}, '{8'h83, 5'b01100}, '{8'ha3, 5'b00101},
		'{8'ha3, 5'b01100}, '{8'h0f, 5'b00001}, '{8'h0f, 5'b00100}, '{8'h00, 5'b00101},
		'{8'h00, 5'b01100}, '{8'h02, 5'b11101}, '{8'h01, 5'b00100}};

	lp_osc_ctrl #(.WINDOW_CYCLES(20), .ARM_CYCLES(4)) lp_osc_ctrl_i (.core_clk_in(clk),
		.reset_n_in(reset_n), .config_in(cfg), .watchdog_enable_in(wdt), .sleep_in(sleep),
		.powerup_timer_done_in(pdone), .sys_clk_ready_in(ready), .sys_clk_toggle_in(toggle),
		.switch_done_in(done), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
		.rdata_out(rdata), .osc_enable_out(en), .current_source_out(cur),
		.switch_request_out(req), .next_source_out(nxt), .clock_fail_trap_out(trap));

	sys_clk_model sys_clk_model_i (.core_clk_in(clk), .reset_n_in(reset_n),
		.switch_request_in(req), .stop_in(stop), .delay_in(delay), .ready_out(ready),
		.toggle_out(toggle), .switch_done_out(done));

	// ========================================
	// Clock, trap count and hang guard
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	always @(posedge clk) begin
		if (trap === 1'b1)
			traps++;
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			end_sim();
		end
	end

	// ========================================
	// Tasks
	task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", n, exp, seen);
		end
	endtask : chk

	task automatic end_sim();
		if (num_errors == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_sim

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc

	task automatic rst(input config_bits_t c);
		@(posedge clk);
		reset_n <= 1'b0;
		cfg <= c;
		wdt <= 1'b0;
		sleep <= 1'b0;
		pdone <= 1'b1;
		stop <= 1'b0;
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		repeat (2) @(posedge clk);
	endtask : rst

	task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg

	// Read data only stand in the slot after the strobe
	task automatic rd_reg(input logic [ADDR_W-1:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		rv = rdata;
	endtask : rd_reg

	task automatic poll(input logic [1:0] st);
		for (i = 0; i < 20; i++) begin
			rd_reg(REG_OSC_STATUS);
			if (rv[5:4] === st)
				break;
		end
		chk("monitor state", 16'(rv[5:4]), 16'(st));
	endtask : poll

	// ========================================
	// Main sequence
	initial begin
		reset_n = 1'b0;
		cfg = '0;
		{wdt, sleep, pdone, wr, rd, stop} = 6'h08;
		addr = '0;
		wdata = '0;
		delay = 8'h03;
		num_errors = 0;
		tests_run = 0;
		foreach (rows[r]) begin
			rst(rows[r].c);
			wdt <= rows[r].f[4];
			sleep <= rows[r].f[3];
			pdone <= rows[r].f[2];
			cyc(4);
			chk("current source", 16'(cur), 16'(rows[r].c[7:5]));
			chk("secondary enable", 16'(en.secondary), 16'(rows[r].f[1]));
			chk("low_power_rc_osc enable", 16'(en.low_power_rc), 16'(rows[r].f[0]));
		end
		chk("traps with clock alive", 16'(traps), 16'h0);
		// Failure on a crystal source with a slow switch pending
		rst(8'h80);
		wdt <= 1'b1;
		delay <= 8'hc8;
		poll(2'h1);
		poll(2'h2);
		wr_reg(REG_OSC_CONTROL, 16'h0201);
		cyc(1);
		chk("request pending", 16'(req), 16'h1);
		chk("next source pending", 16'(nxt), 16'(SRC_PRIMARY));
		chk("primary while pending", 16'(en.primary), 16'h1);
		@(posedge clk);
		stop <= 1'b1;
		for (i = 0; i < 40 && traps == 0; i++)
			@(posedge clk);
		#1;
		chk("source after failure", 16'(cur), 16'(SRC_FAST_RC));
		chk("request after failure", 16'(req), 16'h0);
		cyc(30);
		chk("trap pulses", 16'(traps), 16'h1);
		chk("fast rc enable", 16'(en.fast_rc), 16'h1);
		chk("primary after failure", 16'(en.primary), 16'h0);
		chk("low_power_rc_osc through failure", 16'(en.low_power_rc), 16'h1);
		rd_reg(REG_OSC_CONTROL);
		chk("fail flag", 16'(rv[3]), 16'h1);
		chk("current field", 16'(rv[14:12]), 16'h0);
		poll(2'h3);
		@(posedge clk);
		stop <= 1'b0;
		delay <= 8'h03;
		wr_reg(REG_OSC_CONTROL, 16'h0501);
		rd_reg(REG_OSC_CONTROL);
		chk("fail flag after switch", 16'(rv[3]), 16'h0);
		chk("next source after write", 16'(nxt), 16'(SRC_LOW_POWER_RC));
		for (i = 0; i < 20 && cur !== SRC_LOW_POWER_RC; i++)
			@(posedge clk);
		chk("source after switch", 16'(cur), 16'(SRC_LOW_POWER_RC));
		// Dead clock while asleep
		rst(8'h80);
		poll(2'h2);
		@(posedge clk);
		sleep <= 1'b1;
		stop <= 1'b1;
		cyc(60);
		chk("trap pulses in sleep", 16'(traps), 16'h1);
		chk("low_power_rc_osc in sleep", 16'(en.low_power_rc), 16'h0);
		// Switching disabled, keep-on set, then Sleep
		rst(8'h02);
		wr_reg(REG_OSC_CONTROL, 16'h0403);
		@(posedge clk);
		sleep <= 1'b1;
		cyc(3);
		chk("request refused", 16'(req), 16'h0);
		chk("secondary kept on", 16'(en.secondary), 16'h1);
		rd_reg(4'h7);
		chk("unmapped read", rv, 16'h0000);
		cyc(1);
		chk("read data after slot", rdata, 16'h0000);
		end_sim();
	end
endmodule : testbench
